// File: hw/debug_port_map.svh
`ifndef DEBUG_PORT_MAP_SVH
`define DEBUG_PORT_MAP_SVH

// register offsets on the port's internal register bus
`define DP_LINK_CONTROL_B_ADDR    4'h3
`define DP_KEY_STATUS_ADDR        4'h7
`define DP_SYS_RESET_REQ_ADDR     4'h8
`define DP_PORT_CLOCK_CTRL_ADDR   4'h9
`define DP_SYS_CONTROL_ADDR       4'hA
`define DP_SYS_STATUS_ADDR        4'hB
`define DP_CRC_STATUS_ADDR        4'hC

// link control b field positions
`define DP_NO_ACK_DISABLE_BIT     4
`define DP_CONTENTION_DIS_BIT     3
`define DP_PORT_DISABLE_BIT       2

// key status field positions
`define DP_UROW_KEY_BIT           5
`define DP_NVM_KEY_BIT            4
`define DP_ERASE_KEY_BIT          3

// system control field positions
`define DP_USER_ROW_FINAL_BIT     1
`define DP_CLOCK_REQUEST_BIT      0

// system status field positions
`define DP_RESET_ACTIVE_BIT       5
`define DP_IN_SLEEP_BIT           4
`define DP_NVM_START_BIT          3
`define DP_UROW_START_BIT         2
`define DP_LOCK_STATE_BIT         0

// reset values and signatures
`define DP_RESET_SIGNATURE        8'h59
`define DP_CLOCK_SELECT_RESET     2'h3
`define DP_LOCK_STATE_RESET       1'h1

// port clock selection codes and rates
`define DP_CLK_SEL_16MHZ          2'h1
`define DP_CLK_SEL_8MHZ           2'h2
`define DP_CLK_SEL_4MHZ           2'h3
`define DP_SYS_CLOCK_KHZ          50000
`define DP_PORT_CLOCK_16MHZ_KHZ   16000
`define DP_PORT_CLOCK_8MHZ_KHZ    8000
`define DP_PORT_CLOCK_4MHZ_KHZ    4000

`endif

// File: hw/debug_port_pkg.sv
package debug_port_pkg;

    typedef struct packed {
        logic       active;
        logic       no_ack_disable;
        logic       contention_detect_disable;
        logic       urow_key;
        logic       nvm_key;
        logic       erase_key;
        logic [7:0] reset_value;
        logic [1:0] clock_select;
        logic       user_row_final;
        logic       clock_request;
        logic       reset_seen;
        logic       sleep;
        logic       nvm_start;
        logic       urow_start;
        logic       lock;
        logic [2:0] crc;
        logic       sys_rst_prev;
        logic [7:0] rdata;
        logic       rvalid;
        logic       phy_reset;
        logic       final_start;
        logic       nack;
    } access_state_t;

    typedef struct packed {
        logic [15:0] acc;
        logic        tick;
    } divider_state_t;

endpackage

// File: hw/port_clock_divider.sv
`timescale 1ns/10ps
`default_nettype none
`include "debug_port_map.svh"

// fractional divider: 50 MHz has no integer ratio to 16 or 8 MHz, so a
// phase accumulator spreads the ticks; average rate is exact, jitter one cycle
module port_clock_divider
    import debug_port_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       run,
    input  wire logic [1:0] select,
    output logic            tick
);

    localparam logic [16:0] modulus = 17'(`DP_SYS_CLOCK_KHZ);

    divider_state_t s_q;
    divider_state_t s_d;
    logic [16:0]    step;
    logic [16:0]    sum;

    // rate per selection; the reserved code runs at the safe 4 MHz rate
    always_comb begin
        case (select)
            `DP_CLK_SEL_16MHZ: step = 17'(`DP_PORT_CLOCK_16MHZ_KHZ);
            `DP_CLK_SEL_8MHZ:  step = 17'(`DP_PORT_CLOCK_8MHZ_KHZ);
            default:           step = 17'(`DP_PORT_CLOCK_4MHZ_KHZ);
        endcase
    end

    // accumulate and wrap, one tick per wrap
    always_comb begin
        s_d = s_q;
        sum = {1'b0, s_q.acc} + step;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.acc = 16'h0000;
        end else if (sum >= modulus) begin
            s_d.acc = 16'(sum - modulus);
            s_d.tick = 1'b1;
        end else begin
            s_d.acc = sum[15:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule
`default_nettype wire

// File: hw/debug_port_access_registers.sv
// Notes on behaviour
// - no-ack disable suppresses nack on system reset
// - contention-detect disable stops contention detection
// - port disable: phy off, reset, keys cleared
// - user-row key bit reads key active
// - memory-program key bit clears when programming done
// - chip-erase key bit clears when erase done
// - signature 0x59 holds system reset while written
// - any other value releases system reset
// - reset request reads bit0 held, others zero
// - own system reset never resets this logic
// - clock select: 1=16, 2=8, 3=4 MHz
// - port clock defaults to 4 MHz
// - user-row-final write starts flash programming
// - user-row-final writable only with user-row key
// - clock request bit keeps system clock requested
// - clock request set on enable, cleared on disable
// - reset-active flag sticky, cleared on read
// - in-sleep reads system idle or deeper sleep
// - lock state reads locked, reset value one
// - crc status one-hot: off, busy, ok, fail
// - registers reachable only from external debug link
`timescale 1ns/10ps
`default_nettype none
`include "debug_port_map.svh"

module debug_port_access_registers
    import debug_port_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       port_enable_request,
    input  wire logic [3:0] reg_addr,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rdata_valid,
    input  wire logic       urow_key_accept,
    input  wire logic       nvm_key_accept,
    input  wire logic       erase_key_accept,
    input  wire logic       nvm_program_done,
    input  wire logic       chip_erase_done,
    input  wire logic       load_store_active,
    input  wire logic       contention_seen,
    input  wire logic       sys_reset_in,
    input  wire logic       sys_sleep,
    input  wire logic       nvm_program_ready,
    input  wire logic       user_row_program_ready,
    input  wire logic       lock_in,
    input  wire logic [2:0] crc_state_in,
    output logic            port_active,
    output logic            phy_reset,
    output logic            contention_detect_enable,
    output logic            contention_error,
    output logic            nack_send,
    output logic            system_reset_request,
    output logic            system_clock_request,
    output logic            user_row_final_start,
    output logic            port_clock_tick
);

    access_state_t s_q;
    access_state_t s_d;
    logic          wr_ok;
    logic          rd_ok;
    logic          reset_hold;
    logic          sys_rst_any;
    logic [7:0]    read_mux;

    // all state lives in one packed struct: one comb copy, one flop
    // bank; the pulses (phy reset, final start, nack, read valid) are
    // cleared at the top of the comb block so they last one cycle
    // only, and every level keeps its value unless a cause names it.
    // the read data is held between reads on purpose: the host may
    // look at it late without a second strobe.
    // the status mirrors add one cycle of delay; a host polling them
    // sees a change no sooner than two edges after the system side.

    // only the link's instruction decoder drives this port; the processor
    // has no path here, so no cpu-side decode exists at all
    assign wr_ok = reg_write & s_q.active;
    assign rd_ok = reg_read & s_q.active;

    // the hold follows the stored value, so it lasts exactly as long
    // as the signature stays written
    assign reset_hold  = (s_q.reset_value == `DP_RESET_SIGNATURE);
    assign sys_rst_any = sys_reset_in | reset_hold;

    // read side notes:
    // - the mux is purely combinational on the address, so a read
    //   strobe with a stale address still returns a defined byte
    // - the port disable bit is write-only and never shows up here
    // - the reset request register shows the hold, not the stored
    //   byte, so a host cannot read back a partial signature
    // - offsets of the physical-layer registers this block does not
    //   own read zero rather than aliasing a mapped register
    // read decode; unlisted bit positions tie to zero
    always_comb begin
        read_mux = 8'h00;
        if (reg_addr == `DP_LINK_CONTROL_B_ADDR) begin
            read_mux[`DP_NO_ACK_DISABLE_BIT] = s_q.no_ack_disable;
            read_mux[`DP_CONTENTION_DIS_BIT] = s_q.contention_detect_disable;
        end else if (reg_addr == `DP_KEY_STATUS_ADDR) begin
            read_mux[`DP_UROW_KEY_BIT]  = s_q.urow_key;
            read_mux[`DP_NVM_KEY_BIT]   = s_q.nvm_key;
            read_mux[`DP_ERASE_KEY_BIT] = s_q.erase_key;
        end else if (reg_addr == `DP_SYS_RESET_REQ_ADDR) begin
            read_mux[0] = reset_hold;
        end else if (reg_addr == `DP_PORT_CLOCK_CTRL_ADDR) begin
            read_mux[1:0] = s_q.clock_select;
        end else if (reg_addr == `DP_SYS_CONTROL_ADDR) begin
            read_mux[`DP_USER_ROW_FINAL_BIT] = s_q.user_row_final;
            read_mux[`DP_CLOCK_REQUEST_BIT]  = s_q.clock_request;
        end else if (reg_addr == `DP_SYS_STATUS_ADDR) begin
            read_mux[`DP_RESET_ACTIVE_BIT] = s_q.reset_seen;
            read_mux[`DP_IN_SLEEP_BIT]     = s_q.sleep;
            read_mux[`DP_NVM_START_BIT]    = s_q.nvm_start;
            read_mux[`DP_UROW_START_BIT]   = s_q.urow_start;
            read_mux[`DP_LOCK_STATE_BIT]   = s_q.lock;
        end else if (reg_addr == `DP_CRC_STATUS_ADDR) begin
            read_mux[2:0] = s_q.crc;
        end else begin
            read_mux = 8'h00;
        end
    end

    // ordering inside the next-state block matters:
    // 1. pulses default low and mirrors sample their inputs
    // 2. read capture and the sticky reset flag
    // 3. nack detection on a fresh system reset edge
    // 4. key set and retire strobes
    // 5. ordinary register writes
    // 6. enable, which overrides the clock fields
    // 7. disable, last, so it beats any write or key set in the
    //    same cycle; a key accepted while the host disables the
    //    port must not survive the disable
    // next state of the whole register file
    always_comb begin
        s_d = s_q;
        s_d.phy_reset   = 1'b0;
        s_d.final_start = 1'b0;
        s_d.nack        = 1'b0;
        s_d.rvalid      = rd_ok;
        s_d.sys_rst_prev = sys_rst_any;

        // status sampling; the flags mirror the system side each cycle
        s_d.sleep      = sys_sleep;
        s_d.nvm_start  = nvm_program_ready;
        s_d.urow_start = user_row_program_ready;
        s_d.lock       = lock_in;
        s_d.crc        = crc_state_in;

        // read data is registered, one cycle behind the strobe
        if (rd_ok) begin
            s_d.rdata = read_mux;
        end

        // a read and a still-active reset in one cycle leave the flag
        // set; clearing it then would hide a reset that is still
        // going on, and the next read would wrongly show zero.
        // the flag covers both the outside reset and our own hold,
        // so the host can see its own request take effect.
        // sticky reset flag: read clears, but an active reset wins
        if (rd_ok && reg_addr == `DP_SYS_STATUS_ADDR) begin
            s_d.reset_seen = 1'b0;
        end
        if (sys_rst_any) begin
            s_d.reset_seen = 1'b1;
        end

        // nack on a fresh system reset during a load or store
        if (sys_rst_any && !s_q.sys_rst_prev && load_store_active && s_q.active) begin
            s_d.nack = !s_q.no_ack_disable;
        end

        // keys are only taken while the port is up; a key decode that
        // arrives on a dead port would otherwise reappear at enable.
        // the user-row key has no done strobe: only a disable clears
        // it, since the host ends that flow itself with the final bit.
        // a set and a done in one cycle keep the key set.
        // key tracking; done strobes retire single-use keys
        if (urow_key_accept && s_q.active) begin
            s_d.urow_key = 1'b1;
        end
        if (nvm_key_accept && s_q.active) begin
            s_d.nvm_key = 1'b1;
        end else if (nvm_program_done) begin
            s_d.nvm_key = 1'b0;
        end
        if (erase_key_accept && s_q.active) begin
            s_d.erase_key = 1'b1;
        end else if (chip_erase_done) begin
            s_d.erase_key = 1'b0;
        end

        // register writes
        if (wr_ok) begin
            if (reg_addr == `DP_LINK_CONTROL_B_ADDR) begin
                s_d.no_ack_disable            = reg_wdata[`DP_NO_ACK_DISABLE_BIT];
                s_d.contention_detect_disable = reg_wdata[`DP_CONTENTION_DIS_BIT];
            end else if (reg_addr == `DP_SYS_RESET_REQ_ADDR) begin
                s_d.reset_value = reg_wdata;
            end else if (reg_addr == `DP_PORT_CLOCK_CTRL_ADDR) begin
                s_d.clock_select = reg_wdata[1:0];
            end else if (reg_addr == `DP_SYS_CONTROL_ADDR) begin
                s_d.clock_request = reg_wdata[`DP_CLOCK_REQUEST_BIT];
                if (s_q.urow_key) begin
                    s_d.user_row_final = reg_wdata[`DP_USER_ROW_FINAL_BIT];
                    s_d.final_start    = reg_wdata[`DP_USER_ROW_FINAL_BIT];
                end
            end else begin
                s_d.rdata = s_q.rdata;
            end
        end

        // enabling brings the port up at the default clock with the
        // system clock requested
        if (port_enable_request && !s_q.active) begin
            s_d.active        = 1'b1;
            s_d.clock_request = 1'b1;
            s_d.clock_select  = `DP_CLOCK_SELECT_RESET;
        end

        // disabling wipes configuration and keys; the reset request
        // register is left alone so a held system reset is not dropped
        if (wr_ok && reg_addr == `DP_LINK_CONTROL_B_ADDR &&
            reg_wdata[`DP_PORT_DISABLE_BIT]) begin
            s_d.active                    = 1'b0;
            s_d.phy_reset                 = 1'b1;
            s_d.no_ack_disable            = 1'b0;
            s_d.contention_detect_disable = 1'b0;
            s_d.urow_key                  = 1'b0;
            s_d.nvm_key                   = 1'b0;
            s_d.erase_key                 = 1'b0;
            s_d.user_row_final            = 1'b0;
            s_d.clock_select              = `DP_CLOCK_SELECT_RESET;
            s_d.clock_request             = 1'b0;
        end
    end

    // reset values: clock select starts at the slow safe rate and the
    // lock state reads locked until the system side says otherwise,
    // so a host polling right after reset never sees an unlocked part
    // by accident.
    // the reset is synchronous; srst must be held for at least one
    // rising edge, and the first enable may come on the next edge.
    // only srst resets this logic; the system reset this block raises
    // is an output and loops back only into the reset flag and the nack, never as a reset
    always_ff @(posedge clock) begin
        if (srst) begin
            s_q              <= '0;
            s_q.clock_select <= `DP_CLOCK_SELECT_RESET;
            s_q.lock         <= `DP_LOCK_STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // the link logic runs from the single system clock and moves only
    // on this enable pulse; no second clock domain exists, so nothing
    // here needs a synchroniser.
    // the divider is held while the port is down, which saves power
    // and restarts the phase cleanly at enable.
    // a select change takes effect on the next accumulate step, with
    // at most one short or long tick at the change.
    // port clock enable for the link-facing logic
    port_clock_divider u_divider (
        .clock  (clock),
        .srst   (srst),
        .run    (s_q.active),
        .select (s_q.clock_select),
        .tick   (port_clock_tick)
    );

    // contention detection only while active and not disabled
    assign contention_detect_enable = s_q.active & ~s_q.contention_detect_disable;
    assign contention_error         = contention_seen & contention_detect_enable;

    // outputs: everything but the two contention nets and the reset
    // request comes straight from a flop.
    // the reset request is a compare on a stored byte, so it is
    // glitch-free while that byte does not change.
    // limitation: the hold stays across a port disable; the host must
    // write another value to release the system before it leaves.
    // the contention nets are combinational so a collision is flagged
    // in the same cycle the physical layer sees it.
    assign reg_rdata            = s_q.rdata;
    assign reg_rdata_valid      = s_q.rvalid;
    assign port_active          = s_q.active;
    assign phy_reset            = s_q.phy_reset;
    assign nack_send            = s_q.nack;
    assign system_reset_request = reset_hold;
    assign system_clock_request = s_q.clock_request;
    assign user_row_final_start = s_q.final_start;

endmodule
`default_nettype wire

// File: bench/port_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "debug_port_map.svh"

module port_checker (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic       port_enable_request,
    input wire logic [3:0] reg_addr,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rdata_valid,
    input wire logic       contention_seen,
    input wire logic       port_active,
    input wire logic       phy_reset,
    input wire logic       contention_detect_enable,
    input wire logic       contention_error,
    input wire logic       system_reset_request,
    input wire logic       system_clock_request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic rst_wr;
    logic dis_wr;
    // decoded accepted writes, so each property reads as one cause
    assign rst_wr = reg_write && port_active && reg_addr == `DP_SYS_RESET_REQ_ADDR;
    assign dis_wr = reg_write && port_active && reg_addr == `DP_LINK_CONTROL_B_ADDR
                    && reg_wdata[`DP_PORT_DISABLE_BIT];

    AST_READ_ANSWER: assert property (reg_read && port_active |=> reg_rdata_valid)
        else $error("accepted read gave no valid");
    AST_READ_REFUSED: assert property (reg_read && !port_active |=> !reg_rdata_valid)
        else $error("read answered while port inactive");
    AST_RESET_HOLD: assert property (rst_wr && reg_wdata == 8'h59 |=> system_reset_request)
        else $error("signature did not raise system reset");
    AST_RESET_RELEASE: assert property (rst_wr && reg_wdata != 8'h59 |=> !system_reset_request)
        else $error("other value did not release system reset");
    AST_CONTENTION: assert property (contention_error == (contention_seen && contention_detect_enable))
        else $error("contention error not gated by enable");
    AST_DETECT_IDLE: assert property (!port_active |-> !contention_detect_enable)
        else $error("contention detect on while inactive");
    AST_DISABLE: assert property (dis_wr |=> !port_active && phy_reset ##1 !phy_reset)
        else $error("port disable did not reset port");
    AST_SYSTEM_CLOCK_REQUEST_OFF: assert property (dis_wr |=> !system_clock_request)
        else $error("clock request kept after disable");
    AST_ENABLE: assert property (port_enable_request && !port_active |=> port_active && system_clock_request)
        else $error("enable did not raise active and clock request");
    AST_OWN_RESET: assert property (system_reset_request && port_active && !dis_wr |=> port_active)
        else $error("own system reset dropped the port");

    cover property (dis_wr);
    cover property (rst_wr && reg_wdata == 8'h59);
    cover property (reg_read && !port_active);
endmodule

bind debug_port_access_registers port_checker port_checker_i (.clock, .srst,
    .port_enable_request, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata_valid,
    .contention_seen, .port_active, .phy_reset, .contention_detect_enable,
    .contention_error, .system_reset_request, .system_clock_request);
`default_nettype wire

// File: bench/host_model.sv
`timescale 1ns/10ps
`default_nettype none

// external programmer: one-cycle strobes launched off the falling edge
module host_model (
    input  wire logic       clock,
    output logic      [3:0] reg_addr,
    output logic            reg_write,
    output logic            reg_read,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rdata_valid
);
    initial begin
        reg_addr = 4'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 8'h00;
    end
    // also ends memory and user-row programming (reset request, final bit)
    task automatic wr(input logic [3:0] a, input logic [7:0] dat);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = dat;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
        reg_wdata = ~dat;
    endtask
    // answer is sampled on the falling edge, half a cycle after the take edge
    task automatic rd(input logic [3:0] a, output logic [7:0] dat, output logic ok);
        @(negedge clock);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        dat = reg_rdata;
        ok = reg_rdata_valid;
    endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "debug_port_map.svh"

module tb;
    logic       clock;
    logic       srst;
    logic [5:0] ev;
    logic [9:0] lv;
    logic [3:0] reg_addr;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_rdata_valid;
    logic       port_active;
    logic       system_clock_request;
    logic       contention_error;
    logic       system_reset_request;
    logic       port_clock_tick;
    logic [2:0] ob;
    logic [7:0] d;
    logic       v;
    int         fails;
    int         total_checks;
    int         n;

    // event pulses in ev, levels in lv, pulsed outputs gathered in ob
    debug_port_access_registers debug_port_access_registers_i (.clock(clock), .srst(srst),
        .port_enable_request(ev[0]), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .urow_key_accept(ev[1]), .nvm_key_accept(ev[2]),
        .erase_key_accept(ev[3]), .nvm_program_done(ev[4]), .chip_erase_done(ev[5]),
        .load_store_active(lv[0]), .contention_seen(lv[1]), .sys_reset_in(lv[2]),
        .sys_sleep(lv[3]), .nvm_program_ready(lv[4]), .user_row_program_ready(lv[5]),
        .lock_in(lv[6]), .crc_state_in(lv[9:7]), .port_active(port_active),
        .phy_reset(ob[0]), .contention_detect_enable(), .contention_error(contention_error),
        .nack_send(ob[1]), .system_reset_request(system_reset_request),
        .system_clock_request(system_clock_request), .user_row_final_start(ob[2]),
        .port_clock_tick(port_clock_tick));

    host_model host_model_i (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid));

    task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        host_model_i.rd(a, d, v);
        chk("read valid", 16'(v), 16'h1);
        chk("read data", 16'(d), 16'(e));
    endtask
    // count a pulsed output over three cycles, starting now
    task automatic win(input int b, output int c);
        c = 0;
        repeat (3) begin
            c += int'(ob[b] === 1'b1);
            @(negedge clock);
        end
    endtask
    task automatic pulse(input int b);
        @(negedge clock);
        ev[b] = 1'b1;
        @(negedge clock);
        ev[b] = 1'b0;
    endtask

    task automatic t_defaults;
        host_model_i.rd(`DP_KEY_STATUS_ADDR, d, v);
        chk("inactive valid", 16'(v), 16'h0);
        pulse(0);
        chk("clock request", 16'(system_clock_request), 16'h1);
        rd_chk(`DP_PORT_CLOCK_CTRL_ADDR, 8'h03);
        rd_chk(`DP_SYS_STATUS_ADDR, 8'h01);
        rd_chk(`DP_SYS_CONTROL_ADDR, 8'h01);
        rd_chk(`DP_SYS_RESET_REQ_ADDR, 8'h00);
        host_model_i.wr(4'h5, 8'hFF);
        rd_chk(4'h5, 8'h00);
    endtask
    task automatic t_keys;
        host_model_i.wr(`DP_SYS_CONTROL_ADDR, 8'h03);
        win(2, n);
        chk("final without key", 16'(n), 16'h0);
        pulse(1);
        pulse(2);
        pulse(3);
        rd_chk(`DP_KEY_STATUS_ADDR, 8'h38);
        host_model_i.wr(`DP_SYS_CONTROL_ADDR, 8'h03);
        win(2, n);
        chk("final start", 16'(n), 16'h1);
        pulse(4);
        rd_chk(`DP_KEY_STATUS_ADDR, 8'h28);
        pulse(5);
        rd_chk(`DP_KEY_STATUS_ADDR, 8'h20);
    endtask
    // reset held during a load, then released; sticky flag needs two reads
    task automatic t_reset_req;
        lv[0] = 1'b1;
        host_model_i.wr(`DP_SYS_RESET_REQ_ADDR, `DP_RESET_SIGNATURE);
        chk("reset out", 16'(system_reset_request), 16'h1);
        win(1, n);
        chk("nack", 16'(n), 16'h1);
        rd_chk(`DP_SYS_RESET_REQ_ADDR, 8'h01);
        rd_chk(`DP_SYS_STATUS_ADDR, 8'h21);
        chk("port active", 16'(port_active), 16'h1);
        host_model_i.wr(`DP_SYS_RESET_REQ_ADDR, 8'h5A);
        chk("reset out", 16'(system_reset_request), 16'h0);
        host_model_i.rd(`DP_SYS_STATUS_ADDR, d, v);
        rd_chk(`DP_SYS_STATUS_ADDR, 8'h01);
        lv[0] = 1'b0;
    endtask
    task automatic t_link;
        lv[1:0] = 2'h3;
        @(negedge clock);
        chk("contention", 16'(contention_error), 16'h1);
        host_model_i.wr(`DP_LINK_CONTROL_B_ADDR, 8'h18);
        chk("contention", 16'(contention_error), 16'h0);
        rd_chk(`DP_LINK_CONTROL_B_ADDR, 8'h18);
        host_model_i.wr(`DP_SYS_RESET_REQ_ADDR, `DP_RESET_SIGNATURE);
        win(1, n);
        chk("nack disabled", 16'(n), 16'h0);
        host_model_i.wr(`DP_SYS_RESET_REQ_ADDR, 8'h00);
        lv[1:0] = 2'h0;
    endtask
    task automatic t_status;
        lv[6:2] = 5'h0F;
        repeat (2) @(negedge clock);
        rd_chk(`DP_SYS_STATUS_ADDR, 8'h3C);
        lv[5:2] = 4'h0;
        for (int i = 0; i < 4; i++) begin
            lv[9:7] = 3'((1 << i) >> 1);
            repeat (2) @(negedge clock);
            rd_chk(`DP_CRC_STATUS_ADDR, 8'((1 << i) >> 1));
        end
    endtask
    // slowest first so the fast code is left set for the disable test
    task automatic t_clock;
        int e;
        for (int s = 3; s > 0; s--) begin
            host_model_i.wr(`DP_PORT_CLOCK_CTRL_ADDR, 8'(s));
            e = (`DP_PORT_CLOCK_16MHZ_KHZ * 2000 / `DP_SYS_CLOCK_KHZ) >> s;
            n = 0;
            repeat (1000) begin
                @(negedge clock);
                n += int'(port_clock_tick === 1'b1);
            end
            chk("tick count", 16'(n >= e - 2 && n <= e + 2), 16'h1);
        end
    endtask
    task automatic t_disable;
        host_model_i.wr(`DP_LINK_CONTROL_B_ADDR, 8'h04);
        win(0, n);
        chk("phy reset", 16'(n), 16'h1);
        chk("active", 16'(port_active), 16'h0);
        chk("clock request", 16'(system_clock_request), 16'h0);
        pulse(0);
        rd_chk(`DP_KEY_STATUS_ADDR, 8'h00);
        rd_chk(`DP_LINK_CONTROL_B_ADDR, 8'h00);
        rd_chk(`DP_PORT_CLOCK_CTRL_ADDR, 8'h03);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        srst = 1'b1;
        ev = 6'h00;
        lv = 10'h040;
        fails = 0;
        total_checks = 0;
        repeat (5) @(negedge clock);
        srst = 1'b0;
        t_defaults;
        t_keys;
        t_reset_req;
        t_link;
        t_status;
        t_clock;
        t_disable;
        close_out;
    end
    // run needs about 3100 cycles; a hang is cut well beyond that
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        close_out;
    end
endmodule
`default_nettype wire
